// [rtl/dtr_pkg.sv]
package dtr_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned WDT_TIME_MS = 2000;
  localparam int unsigned WDT_CYC = WDT_TIME_MS * CYC_PER_MS;
  // discharge time counts in half-minute units
  localparam int unsigned DT_UNIT_MS = 30000;
  localparam int unsigned DT_UNIT_CYC = DT_UNIT_MS * CYC_PER_MS;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CFGA_LO = 8'h00;
  localparam logic [7:0] OFS_CFGA_HI = 8'h04;
  localparam logic [7:0] OFS_CFGB = 8'h08;
  localparam logic [7:0] OFS_BALANCING_SWITCH_CONTROL_GROUP = 8'h0C;
  localparam logic [7:0] OFS_PWM = 8'h10;
  localparam logic [7:0] OFS_PSB = 8'h14;
  localparam logic [7:0] OFS_BRIDGE_TRANSFER_GROUP_LO = 8'h18;
  localparam logic [7:0] OFS_BRIDGE_TRANSFER_GROUP_HI = 8'h1C;
  localparam logic [7:0] OFS_CMD = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  // ****************************************
  // fields
  // ****************************************
  localparam int unsigned DISCHARGE_DURATION_SETTING_LSB = 44;
  localparam int unsigned DISCHARGE_DURATION_SETTING_RD_LSB = 12;
  localparam int unsigned CMD_KICK_BIT = 0;
  localparam int unsigned CMD_COMMIT_BIT = 1;
  localparam int unsigned MON_EN_BIT = 11;
  localparam logic [47:0] CFGA_B0_M = 48'h0000_0000_00FF;
  localparam logic [47:0] CFGA_B13_M = 48'h0000_FFFF_FF00;
  localparam logic [47:0] CFGA_B45_M = 48'hFFFF_0000_0000;
  localparam logic [15:0] CFGB_GPIO_M = 16'h000F;
  localparam logic [15:0] CFGB_B0HI_M = 16'h00F0;
  localparam logic [15:0] CFGB_B1_M = 16'hFF00;
  localparam logic [15:0] CFGB_MUTE_M = 16'h0200;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [47:0] CFGA_RST = 48'h0000_0000_0000;
  localparam logic [15:0] CFGB_RST = 16'h0000;
  localparam logic [31:0] PWM_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] PSB_RST = 32'hFFFF_FFFF;
  localparam logic [47:0] BRIDGE_TRANSFER_GROUP_RST = 48'hFFFF_FFFF_FFFF;

  typedef enum logic [1:0] {
    DTR_STANDBY = 2'b00,
    DTR_EXTBAL = 2'b01,
    DTR_SLEEP = 2'b11
  } dtr_state_t;

  // duration of a setting code in half minutes
  function automatic logic [7:0] dtr_units(input logic [3:0] c);
    unique case (c)
      4'h0: dtr_units = 8'h00;
      4'h1: dtr_units = 8'h01;
      4'h2: dtr_units = 8'h02;
      4'h3: dtr_units = 8'h04;
      4'h4: dtr_units = 8'h06;
      4'h5: dtr_units = 8'h08;
      4'h6: dtr_units = 8'h0A;
      4'h7: dtr_units = 8'h14;
      4'h8: dtr_units = 8'h1E;
      4'h9: dtr_units = 8'h28;
      4'hA: dtr_units = 8'h3C;
      4'hB: dtr_units = 8'h50;
      4'hC: dtr_units = 8'h78;
      4'hD: dtr_units = 8'h96;
      4'hE: dtr_units = 8'hB4;
      4'hF: dtr_units = 8'hF0;
    endcase
  endfunction

  // smallest code whose duration covers the remaining units
  function automatic logic [3:0] dtr_band(input logic [7:0] rem);
    logic [3:0] b;
    b = 4'h0;
    for (int c = 15; c >= 1; c--) begin
      if (rem != 8'h00 && rem <= dtr_units(4'(c))) begin
        b = 4'(c);
      end
    end
    return b;
  endfunction
endpackage

// [rtl/dtr_tmr_if.sv]
`timescale 1ns/1ps
interface dtr_tmr_if;
  logic kick;
  logic restart;
  logic en;
  logic [3:0] setting;
  logic wd_exp;
  logic dt_exp;
  logic dt_run;
  logic [3:0] band;
  modport ctl (output kick, output restart, output en, output setting,
    input wd_exp, input dt_exp, input dt_run, input band);
  modport tmr (input kick, input restart, input en, input setting,
    output wd_exp, output dt_exp, output dt_run, output band);
endinterface

// [rtl/dtr_timers.sv]
`timescale 1ns/1ps
module dtr_timers #(
  parameter int unsigned WDT_CYCLES = dtr_pkg::WDT_CYC,
  parameter int unsigned UNIT_CYCLES = dtr_pkg::DT_UNIT_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  dtr_tmr_if.tmr t
);
  if (WDT_CYCLES < 2 || UNIT_CYCLES < 2) begin : g_chk
    $error("timer counts must be at least 2");
  end

  logic [31:0] wd_cnt_q;
  logic wd_done_q;
  logic wd_exp_q;
  logic [31:0] pre_q;
  logic [7:0] rem_q;
  logic dt_exp_q;

  // ****************************************
  // watchdog
  // ****************************************
  wire wd_end = !wd_done_q && wd_cnt_q == WDT_CYCLES - 1;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wd_cnt_q <= 32'h0000_0000;
      wd_done_q <= 1'b0;
      wd_exp_q <= 1'b0;
    end else if (ce) begin
      wd_cnt_q <= (t.kick || wd_done_q) ? 32'h0000_0000 : wd_cnt_q + 32'h0000_0001;
      wd_done_q <= !t.kick && (wd_done_q || wd_end);
      wd_exp_q <= !t.kick && wd_end;
    end
  end

  // ****************************************
  // discharge timer
  // ****************************************
  wire unit_end = rem_q != 8'h00 && pre_q == UNIT_CYCLES - 1;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pre_q <= 32'h0000_0000;
      rem_q <= 8'h00;
      dt_exp_q <= 1'b0;
    end else if (ce) begin
      if (!t.en) begin
        pre_q <= 32'h0000_0000;
        rem_q <= 8'h00;
        dt_exp_q <= 1'b0;
      end else if (t.restart) begin
        pre_q <= 32'h0000_0000;
        rem_q <= dtr_pkg::dtr_units(t.setting);
        dt_exp_q <= 1'b0;
      end else begin
        pre_q <= (unit_end || rem_q == 8'h00) ? 32'h0000_0000 : pre_q + 32'h0000_0001;
        rem_q <= unit_end ? rem_q - 8'h01 : rem_q;
        dt_exp_q <= unit_end && rem_q == 8'h01;
      end
    end
  end

  assign t.wd_exp = wd_exp_q;
  assign t.dt_exp = dt_exp_q;
  assign t.dt_run = rem_q != 8'h00;
  assign t.band = dtr_pkg::dtr_band(rem_q);
endmodule

// [rtl/dtr_ctrl.sv]
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - duration code 0 disabled, 1..F map 0.5 to 120 minutes.
// - enable input low or code zero: timer off, watchdog clears all config.
// - timer on: watchdog clears A0, A1-3 if monitor off, B gpio bits.
// - discharge expiry clears A1-3 if monitor on, A4-5, switches, B bits 15:4 except mute.
// - readback code gives the band holding the remaining time, 0 when idle.
// - only a commit command restarts the discharge timer.
// - expiry during config A write clears first, then new data is stored.
// - expiry during config reads clears anyway; read data may be mixed.
// - expiry during switch group reads clears them; read data may be mixed.
// - reset gives standby, default registers, discharge off.
// - thermal shutdown stops discharge, clears A, B except mute, bridge group.
// - watchdog expiry with timer running enters extended balancing.
// - watchdog expiry without timer enters sleep, clears every group.
// - discharge expiry after watchdog expiry also enters sleep, full clear.
// - early discharge expiry stops discharge, clears pwm and switch groups.
// - early discharge expiry clears B0 bits 7:4 and B1 except mute.
// - watchdog expires after 2 s without a valid command; each one restarts.
module dtr_ctrl #(
  parameter int unsigned NCELL = 18,
  parameter int unsigned WDT_CYCLES = dtr_pkg::WDT_CYC,
  parameter int unsigned UNIT_CYCLES = dtr_pkg::DT_UNIT_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_enable_input,
  input wire logic thermal_shutdown,
  output logic [NCELL-1:0] switch_on,
  output logic watchdog_expired,
  output logic [1:0] power_state
);
  if (NCELL < 1 || NCELL > 32) begin : g_chk
    $error("NCELL must lie in 1..32");
  end

  // ****************************************
  // state
  // ****************************************
  logic [47:0] cfga_q;
  logic [47:0] stage_q;
  logic [15:0] cfgb_q;
  logic [NCELL-1:0] balancing_switch_control_group_q;
  logic [31:0] pwm_q;
  logic [31:0] psb_q;
  logic [47:0] bridge_transfer_group_q;
  logic wd_exp_q;
  logic dis_off_q;
  dtr_pkg::dtr_state_t state_q;
  dtr_pkg::dtr_state_t state_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [NCELL-1:0] switch_q;

  dtr_tmr_if tif ();

  dtr_timers #(
    .WDT_CYCLES(WDT_CYCLES),
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_tmr (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .t(tif.tmr)
  );

  // ****************************************
  // bus decode
  // ****************************************
  wire setup = psel && !penable;
  wire wr = psel && penable && pready_q && pwrite;
  wire hit_alo = paddr == dtr_pkg::OFS_CFGA_LO;
  wire hit_ahi = paddr == dtr_pkg::OFS_CFGA_HI;
  wire hit_b = paddr == dtr_pkg::OFS_CFGB;
  wire hit_s = paddr == dtr_pkg::OFS_BALANCING_SWITCH_CONTROL_GROUP;
  wire hit_pwm = paddr == dtr_pkg::OFS_PWM;
  wire hit_psb = paddr == dtr_pkg::OFS_PSB;
  wire hit_clo = paddr == dtr_pkg::OFS_BRIDGE_TRANSFER_GROUP_LO;
  wire hit_chi = paddr == dtr_pkg::OFS_BRIDGE_TRANSFER_GROUP_HI;
  wire hit_cmd = paddr == dtr_pkg::OFS_CMD;
  wire hit_st = paddr == dtr_pkg::OFS_STATUS;
  wire mapped = hit_alo || hit_ahi || hit_b || hit_s || hit_pwm || hit_psb
    || hit_clo || hit_chi || hit_cmd || hit_st;
  // status is read-only; writing it is an error
  wire bad = !mapped || (pwrite && hit_st);

  wire kick = wr && hit_cmd && pwdata[dtr_pkg::CMD_KICK_BIT];
  wire commit = wr && hit_cmd && pwdata[dtr_pkg::CMD_COMMIT_BIT];
  wire valid_cmd = kick || commit;

  // ****************************************
  // timer hookup
  // ****************************************
  wire [3:0] new_discharge_duration_setting = stage_q[dtr_pkg::DISCHARGE_DURATION_SETTING_LSB +: 4];
  assign tif.kick = valid_cmd;
  assign tif.restart = commit;
  assign tif.en = timer_enable_input;
  assign tif.setting = new_discharge_duration_setting;

  wire mon_en = cfgb_q[dtr_pkg::MON_EN_BIT];

  // ****************************************
  // reset events
  // ****************************************
  // a timer restart in the same cycle as an expiry still sees the old run
  wire ev_wd_ext = tif.wd_exp && tif.dt_run;
  wire ev_sleep = (tif.wd_exp && !tif.dt_run && !tif.dt_exp)
    || (tif.dt_exp && wd_exp_q);
  wire ev_dt_early = tif.dt_exp && !wd_exp_q;
  wire thsd = thermal_shutdown;

  wire [47:0] clr_a_wd = dtr_pkg::CFGA_B0_M
    | (mon_en ? 48'h0000_0000_0000 : dtr_pkg::CFGA_B13_M);
  wire [47:0] clr_a_dt = dtr_pkg::CFGA_B45_M
    | (mon_en ? dtr_pkg::CFGA_B13_M : 48'h0000_0000_0000);
  wire [47:0] clr_a = ((ev_sleep || thsd) ? 48'hFFFF_FFFF_FFFF : 48'h0000_0000_0000)
    | (ev_wd_ext ? clr_a_wd : 48'h0000_0000_0000)
    | (ev_dt_early ? clr_a_dt : 48'h0000_0000_0000);

  wire [15:0] keep_mute = ~dtr_pkg::CFGB_MUTE_M;
  wire [15:0] clr_b_dt = dtr_pkg::CFGB_B0HI_M
    | (dtr_pkg::CFGB_B1_M & keep_mute);
  wire [15:0] clr_b = (ev_sleep ? 16'hFFFF : 16'h0000)
    | (thsd ? keep_mute : 16'h0000)
    | (ev_wd_ext ? dtr_pkg::CFGB_GPIO_M : 16'h0000)
    | (ev_dt_early ? clr_b_dt : 16'h0000);

  // switch groups: thermal shutdown leaves them alone
  wire clr_sw = ev_sleep || ev_dt_early;
  wire clr_bridge_transfer_group = ev_sleep || ev_wd_ext || thsd;
  wire stop_dis = ev_sleep || ev_dt_early || thsd;

  // ****************************************
  // register next values
  // ****************************************
  wire [47:0] cfga_cl = cfga_q & ~clr_a;
  // committed data lands after the clear of the same cycle
  wire [47:0] cfga_d = commit ? stage_q : cfga_cl;
  wire [47:0] stage_d = {
    (wr && hit_ahi) ? pwdata[15:0] : stage_q[47:32],
    (wr && hit_alo) ? pwdata : stage_q[31:0]};
  wire [15:0] cfgb_d = (wr && hit_b) ? pwdata[15:0] : cfgb_q & ~clr_b;
  wire [NCELL-1:0] balancing_switch_control_group_d = clr_sw ? '0
    : (wr && hit_s) ? pwdata[NCELL-1:0] : balancing_switch_control_group_q;
  wire [31:0] pwm_d = clr_sw ? dtr_pkg::PWM_RST : (wr && hit_pwm) ? pwdata : pwm_q;
  wire [31:0] psb_d = clr_sw ? dtr_pkg::PSB_RST : (wr && hit_psb) ? pwdata : psb_q;
  wire [47:0] bridge_transfer_group_d = clr_bridge_transfer_group ? dtr_pkg::BRIDGE_TRANSFER_GROUP_RST : {
    (wr && hit_chi) ? pwdata[15:0] : bridge_transfer_group_q[47:32],
    (wr && hit_clo) ? pwdata : bridge_transfer_group_q[31:0]};
  // a new expiry wins over a command in the same cycle
  wire wd_exp_d = tif.wd_exp || (wd_exp_q && !valid_cmd);
  wire dis_off_d = stop_dis || (dis_off_q && !commit);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dtr_pkg::DTR_STANDBY: begin
        if (ev_sleep) begin
          state_d = dtr_pkg::DTR_SLEEP;
        end else if (ev_wd_ext) begin
          state_d = dtr_pkg::DTR_EXTBAL;
        end
      end
      dtr_pkg::DTR_EXTBAL: begin
        if (ev_sleep) begin
          state_d = dtr_pkg::DTR_SLEEP;
        end else if (valid_cmd) begin
          state_d = dtr_pkg::DTR_STANDBY;
        end
      end
      dtr_pkg::DTR_SLEEP: begin
        if (valid_cmd) begin
          state_d = dtr_pkg::DTR_STANDBY;
        end
      end
      default: state_d = dtr_pkg::DTR_STANDBY;
    endcase
  end

  // ****************************************
  // read mux
  // ****************************************
  // live registers are read; an expiry mid-read may mix old and new bytes
  wire [31:0] rd_ahi = {16'h0000, cfga_q[47:32]};
  wire [31:0] rd_ahi_band = {rd_ahi[31:16], tif.band,
    rd_ahi[dtr_pkg::DISCHARGE_DURATION_SETTING_RD_LSB-1:0]};
  wire [31:0] rd_st = {19'h0_0000, tif.dt_run, tif.band, dis_off_q,
    wd_exp_q, 2'(state_q), 4'h0};
  wire [31:0] rd_val = hit_alo ? cfga_q[31:0]
    : hit_ahi ? rd_ahi_band
    : hit_b ? {16'h0000, cfgb_q}
    : hit_s ? 32'(balancing_switch_control_group_q)
    : hit_pwm ? pwm_q
    : hit_psb ? psb_q
    : hit_clo ? bridge_transfer_group_q[31:0]
    : hit_chi ? {16'h0000, bridge_transfer_group_q[47:32]}
    : hit_st ? rd_st
    : 32'h0000_0000;

  // ****************************************
  // bus answer
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      pready_q <= setup;
      pslverr_q <= setup && bad;
      prdata_q <= (setup && !pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // status write is refused, so a bad write never reaches a register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfga_q <= dtr_pkg::CFGA_RST;
      stage_q <= dtr_pkg::CFGA_RST;
      cfgb_q <= dtr_pkg::CFGB_RST;
      balancing_switch_control_group_q <= '0;
      pwm_q <= dtr_pkg::PWM_RST;
      psb_q <= dtr_pkg::PSB_RST;
      bridge_transfer_group_q <= dtr_pkg::BRIDGE_TRANSFER_GROUP_RST;
    end else if (ce) begin
      cfga_q <= cfga_d;
      stage_q <= stage_d;
      cfgb_q <= cfgb_d;
      balancing_switch_control_group_q <= balancing_switch_control_group_d;
      pwm_q <= pwm_d;
      psb_q <= psb_d;
      bridge_transfer_group_q <= bridge_transfer_group_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= dtr_pkg::DTR_STANDBY;
      wd_exp_q <= 1'b0;
      dis_off_q <= 1'b1;
      switch_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      wd_exp_q <= wd_exp_d;
      dis_off_q <= dis_off_d;
      switch_q <= (dis_off_d || state_d == dtr_pkg::DTR_SLEEP) ? '0 : balancing_switch_control_group_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign switch_on = switch_q;
  assign watchdog_expired = wd_exp_q;
  assign power_state = state_q;
endmodule

// [bench/dtr_ctrl_monitor.sv]
`timescale 1ns/1ps
module dtr_ctrl_monitor #(
  parameter int unsigned NCELL = 18,
  parameter int unsigned WDT_CYCLES = 50
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_enable_input,
  input wire logic thermal_shutdown,
  input wire logic [NCELL-1:0] switch_on,
  input wire logic watchdog_expired,
  input wire logic [1:0] power_state
);
  // ******
  // idle time since last valid command
  // ******
  int unsigned idle_q;
  wire logic kick;
  assign kick = psel && penable && pready && pwrite && paddr == dtr_pkg::OFS_CMD
    && pwdata[1:0] != 2'b00;
  // saturates so a long idle span cannot wrap back into the window
  always_ff @(posedge mclk) begin
    if (!resetn || kick) begin
      idle_q <= 0;
    end else if (ce && idle_q < 32'h0000_FFFF) begin
      idle_q <= idle_q + 1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // ******
  // checks
  // ******
  ack_next_a: assert property (psel && !penable && ce |=> pready)
    else $error("pready missing after setup");
  ack_single_a: assert property (pready && ce |=> !pready)
    else $error("pready held past one cycle");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  status_ro_a: assert property (psel && !penable && pwrite && ce
    && paddr == dtr_pkg::OFS_STATUS |=> pslverr)
    else $error("status write accepted");
  sleep_off_a: assert property ((power_state == 2'b11) [*2] |-> switch_on == '0)
    else $error("switch on while asleep");
  wd_late_a: assert property (idle_q == WDT_CYCLES + 3 |-> watchdog_expired)
    else $error("watchdog did not expire");
  wd_early_a: assert property ($rose(watchdog_expired) |->
    idle_q + 1 >= WDT_CYCLES && idle_q <= WDT_CYCLES + 2)
    else $error("watchdog expired at wrong time");
  kick_clear_a: assert property (kick |-> ##2 !watchdog_expired && power_state == 2'b00)
    else $error("valid command did not restart");
  exp_state_a: assert property ($rose(watchdog_expired) |-> ##[0:2] power_state != 2'b00)
    else $error("expiry left state in standby");
endmodule

// [bench/dtr_host.sv]
`timescale 1ns/1ps
module dtr_host (
  input wire logic mclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // one transfer; an edge passes first so a release never meets a new setup
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show garbage, not the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// [bench/dtr_ctrl_tb.sv]
`timescale 1ns/1ps
module dtr_ctrl_tb;
  localparam int unsigned WDC = 50;
  localparam int unsigned UC = 20;
  logic mclk, resetn, ce, psel, penable, pwrite, pready, pslverr;
  logic timer_enable_input, thermal_shutdown, watchdog_expired, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, m_p, m_c;
  logic [17:0] switch_on, m_s;
  logic [1:0] power_state;
  logic [47:0] m_a;
  logic [15:0] m_b;
  int bad_count, n_checks;

  dtr_ctrl #(.WDT_CYCLES(WDC), .UNIT_CYCLES(UC)) i_dut (.mclk(mclk), .resetn(resetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_enable_input(timer_enable_input), .thermal_shutdown(thermal_shutdown),
    .switch_on(switch_on), .watchdog_expired(watchdog_expired), .power_state(power_state));
  dtr_host i_host (.mclk(mclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // ******
  // helpers
  // ******
  task automatic give_verdict();
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    i_host.xfer(1'b0, a, 32'h0000_0000, rd, er);
    chk($sformatf("read %h", a), exp, rd);
  endtask
  task automatic ports(input logic [1:0] st, input logic [17:0] sw);
    chk("power_state", {30'h0, st}, {30'h0, power_state});
    chk("switch_on", {14'h0, sw}, {14'h0, switch_on});
  endtask
  task automatic m_clear();
    m_a = '0;
    m_b = '0;
    m_s = '0;
    m_p = 32'hFFFF_FFFF;
    m_c = 32'hFFFF_FFFF;
  endtask
  task automatic cmp_all(input logic [3:0] band);
    rdc(dtr_pkg::OFS_CFGA_LO, m_a[31:0]);
    rdc(dtr_pkg::OFS_CFGA_HI, {16'h0000, band, m_a[43:32]});
    rdc(dtr_pkg::OFS_CFGB, {16'h0000, m_b});
    rdc(dtr_pkg::OFS_BALANCING_SWITCH_CONTROL_GROUP, {14'h0000, m_s});
    rdc(dtr_pkg::OFS_PWM, m_p);
    rdc(dtr_pkg::OFS_BRIDGE_TRANSFER_GROUP_LO, m_c);
  endtask
  // kick first so the watchdog cannot fire while the groups are loaded
  task automatic load(input logic [3:0] code, input logic mon);
    logic [31:0] r;
    r = $urandom;
    m_a = {code, r[27:16], r ^ 32'h5A5A_5A5A};
    m_b = {r[15:12], mon, r[10:0]};
    m_s = r[31:14];
    m_p = ~r;
    m_c = {r[15:0], r[31:16]};
    wr(dtr_pkg::OFS_CMD, 32'h0000_0001);
    wr(dtr_pkg::OFS_CFGA_LO, m_a[31:0]);
    wr(dtr_pkg::OFS_CFGA_HI, {16'h0000, m_a[47:32]});
    wr(dtr_pkg::OFS_CFGB, {16'h0000, m_b});
    wr(dtr_pkg::OFS_BALANCING_SWITCH_CONTROL_GROUP, {14'h0000, m_s});
    wr(dtr_pkg::OFS_PWM, m_p);
    wr(dtr_pkg::OFS_BRIDGE_TRANSFER_GROUP_LO, m_c);
    wr(dtr_pkg::OFS_CMD, 32'h0000_0002);
  endtask

  // ******
  // clock, watchdog, sequence
  // ******
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    give_verdict();
  end
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    timer_enable_input = 1'b0;
    thermal_shutdown = 1'b0;
    bad_count = 0;
    n_checks = 0;
    rd = $urandom(1025);
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    m_clear();
    cmp_all(4'h0);
    rdc(dtr_pkg::OFS_BRIDGE_TRANSFER_GROUP_HI, 32'h0000_FFFF);
    rdc(dtr_pkg::OFS_PSB, 32'hFFFF_FFFF);
    ports(2'b00, '0);
    i_host.xfer(1'b0, 8'h28, 32'h0000_0000, rd, er);
    chk("unmapped error", 32'h1, {31'h0, er});
    i_host.xfer(1'b1, dtr_pkg::OFS_STATUS, 32'hFFFF_FFFF, rd, er);
    chk("status error", 32'h1, {31'h0, er});
    timer_enable_input <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      wr(dtr_pkg::OFS_CFGA_HI, {16'h0000, 4'(c), 12'h000});
      wr(dtr_pkg::OFS_CMD, 32'h0000_0002);
      rdc(dtr_pkg::OFS_CFGA_HI, {16'h0000, 4'(c), 12'h000});
    end
    wr(dtr_pkg::OFS_CFGA_HI, {16'h0000, 4'h2, 12'h000});
    wr(dtr_pkg::OFS_CMD, 32'h0000_0002);
    repeat (25) @(posedge mclk);
    rdc(dtr_pkg::OFS_CFGA_HI, {16'h0000, 4'h1, 12'h000});
    wr(dtr_pkg::OFS_CMD, 32'h0000_0001);
    repeat (12) @(posedge mclk);
    rdc(dtr_pkg::OFS_CFGA_HI, 32'h0000_0000);
    // timer pin low: watchdog expiry clears everything
    timer_enable_input <= 1'b0;
    load(4'h5, 1'b1);
    repeat (2) @(posedge mclk);
    ports(2'b00, m_s);
    repeat (56) @(posedge mclk);
    chk("watchdog_expired", 32'h1, {31'h0, watchdog_expired});
    m_clear();
    ports(2'b11, '0);
    cmp_all(4'h0);
    // watchdog expiry while discharging, then discharge expiry
    timer_enable_input <= 1'b1;
    load(4'h4, 1'b0);
    repeat (55) @(posedge mclk);
    m_a = m_a & ~(dtr_pkg::CFGA_B0_M | dtr_pkg::CFGA_B13_M);
    m_b = m_b & ~dtr_pkg::CFGB_GPIO_M;
    m_c = 32'hFFFF_FFFF;
    ports(2'b01, m_s);
    cmp_all(4'h3);
    rdc(dtr_pkg::OFS_STATUS, 32'h0000_1350);
    repeat (60) @(posedge mclk);
    m_clear();
    ports(2'b11, '0);
    cmp_all(4'h0);
    // discharge expiry with the watchdog still alive
    load(4'h1, 1'b1);
    repeat (10) @(posedge mclk);
    wr(dtr_pkg::OFS_CMD, 32'h0000_0001);
    repeat (20) @(posedge mclk);
    m_a = m_a & ~(dtr_pkg::CFGA_B13_M | dtr_pkg::CFGA_B45_M);
    m_b = m_b & (dtr_pkg::CFGB_GPIO_M | dtr_pkg::CFGB_MUTE_M);
    m_s = '0;
    m_p = 32'hFFFF_FFFF;
    ports(2'b00, '0);
    cmp_all(4'h0);
    // thermal trip keeps the switch group
    timer_enable_input <= 1'b0;
    load(4'h7, 1'b1);
    thermal_shutdown <= 1'b1;
    repeat (2) @(posedge mclk);
    thermal_shutdown <= 1'b0;
    repeat (2) @(posedge mclk);
    m_a = '0;
    m_b = m_b & dtr_pkg::CFGB_MUTE_M;
    m_c = 32'hFFFF_FFFF;
    ports(2'b00, '0);
    cmp_all(4'h0);
    // a stalled clock enable must freeze the watchdog count
    ce <= 1'b0;
    repeat (60) @(posedge mclk);
    ce <= 1'b1;
    @(posedge mclk);
    chk("frozen watchdog", 32'h0, {31'h0, watchdog_expired});
    ports(2'b00, '0);
    give_verdict();
  end
endmodule

bind dtr_ctrl dtr_ctrl_monitor #(.NCELL(NCELL), .WDT_CYCLES(WDT_CYCLES)) i_mon (
  .mclk(mclk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer_enable_input(timer_enable_input),
  .thermal_shutdown(thermal_shutdown), .switch_on(switch_on),
  .watchdog_expired(watchdog_expired), .power_state(power_state));
